// >>> hw/sli_pkg.sv
// package for the status lamp indicator source select block
// Function
// RULE_01: green lit while serial link healthy
// RULE_02: red on link error, green after recovery
// RULE_03: ready lamp mirrors ready output
// RULE_04: mode minus one keeps lamp dark
// RULE_05: mode zero shows selected signals
// RULE_06: mode one default, link status if serial
// RULE_07: green source select, default code 132
// RULE_08: green inversion, default not inverted
// RULE_09: red source select, default code 128
// RULE_10: red inversion, default not inverted
// RULE_11: one signal as green on, red off
// RULE_12: lamp follows signals every cycle
package sli_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [11:0] ADDR_MODE   = 12'h000;
    localparam logic [11:0] ADDR_GREEN  = 12'h004;
    localparam logic [11:0] ADDR_RED    = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam logic [11:0] ADDR_SIGLO  = 12'h010;
    // ==========================================================
    // field layout of source select registers
    localparam int SEL_LSB  = 0;
    localparam int SEL_W    = 8;
    localparam int FLIP_BIT = 8;
    // status register bits
    localparam int ST_GREEN = 0;
    localparam int ST_RED   = 1;
    localparam int ST_READY = 2;
    localparam int ST_COMOK = 3;
    localparam int ST_COMER = 4;
    // ==========================================================
    // lamp source modes (two's complement, 2 bits)
    typedef enum logic [1:0] {
        SLI_MODE_DARK = 2'b11,
        SLI_MODE_SIG  = 2'b00,
        SLI_MODE_COMM = 2'b01
    } sli_mode_t;
    // ==========================================================
    // signal codes and reset values
    localparam logic [7:0] SIG_CONST_OFF = 8'h80;  // code 128
    localparam logic [7:0] SIG_READY     = 8'h84;  // code 132
    localparam logic [7:0] SIG_CONST_ON  = 8'h81;  // code 129
    localparam int         NUM_GEN_SIG   = 128;
    localparam sli_mode_t  MODE_RST      = SLI_MODE_COMM;
    localparam logic       FLIP_RST      = 1'b0;
    // ==========================================================
    // lamp setting carried as one bundle
    typedef struct packed {
        logic       flip;
        logic [7:0] sel;
    } sli_src_t;
endpackage : sli_pkg

// >>> hw/sli_status_lamp.sv
// status lamp source selection with apb register slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
module sli_status_lamp
    import sli_pkg::*;
#(
    parameter bit SERIAL_VARIANT = 1'b1
) (
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [127:0]  outSignals,
    input  wire logic          readyOut,
    input  wire logic          commActive,
    input  wire logic          commError,
    output logic               lampGreen,
    output logic               lampRed,
    output logic               readyLamp
);
    // ==========================================================
    // registers
    sli_mode_t  mode;
    sli_src_t   greenSrc;
    sli_src_t   redSrc;
    logic       commFault;
    logic       wrEn;
    logic       rdEn;
    logic       mapped;

    assign pready  = 1'b1;
    assign wrEn    = psel & penable & pwrite;
    assign rdEn    = psel & penable & ~pwrite;
    assign mapped  = (paddr == ADDR_MODE) || (paddr == ADDR_GREEN) ||
                     (paddr == ADDR_RED) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_SIGLO);
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode <= MODE_RST;  // [RULE_06]
        end else if (wrEn && paddr == ADDR_MODE) begin
            case (pwdata[1:0])
                2'b11:   mode <= SLI_MODE_DARK;
                2'b00:   mode <= SLI_MODE_SIG;
                2'b01:   mode <= SLI_MODE_COMM;
                default: mode <= mode;  // out-of-range values ignored
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            greenSrc <= '{flip: FLIP_RST, sel: SIG_READY};  // [RULE_07] [RULE_08]
        end else if (wrEn && paddr == ADDR_GREEN) begin
            greenSrc <= '{flip: pwdata[FLIP_BIT],
                          sel: pwdata[SEL_LSB +: SEL_W]};
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            redSrc <= '{flip: FLIP_RST, sel: SIG_CONST_OFF};  // [RULE_09] [RULE_10]
        end else if (wrEn && paddr == ADDR_RED) begin
            redSrc <= '{flip: pwdata[FLIP_BIT],
                        sel: pwdata[SEL_LSB +: SEL_W]};
        end
    end

    // ==========================================================
    // pin synchronisers; first stage feeds only the second
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic       readySync;
    logic       activeSync;
    logic       errorSync;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            syncA <= 4'h0;
            syncB <= 4'h0;
        end else begin
            syncA <= {commError, commActive, readyOut, 1'b0};
            syncB <= syncA;
        end
    end
    assign readySync  = syncB[1];
    assign activeSync = syncB[2];
    assign errorSync  = syncB[3];

    logic [127:0] sigA;
    logic [127:0] sigB;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sigA <= '0;
            sigB <= '0;
        end else begin
            sigA <= outSignals;
            sigB <= sigA;
        end
    end

    // error holds red until a healthy exchange is seen
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            commFault <= 1'b0;
        end else if (errorSync) begin
            commFault <= 1'b1;  // [RULE_02]
        end else if (activeSync) begin
            commFault <= 1'b0;  // [RULE_02]
        end
    end

    // ==========================================================
    // signal lookup: codes below 128 are general outputs
    function automatic logic pickSig(input logic [7:0] code,
                                     input logic [127:0] s,
                                     input logic rdy);
        logic v;
        v = 1'b0;
        if (code < 8'h80) begin
            v = s[code[6:0]];
        end else if (code == SIG_READY) begin
            v = rdy;
        end else if (code == SIG_CONST_ON) begin
            v = 1'b1;
        end
        return v;
    endfunction : pickSig

    logic greenSig;
    logic redSig;
    logic sigMode;
    logic next_green;
    logic next_red;
    // combined per cycle so any selection change shows next edge
    assign greenSig = pickSig(greenSrc.sel, sigB, readySync)
                      ^ greenSrc.flip;  // [RULE_08] [RULE_12]
    assign redSig   = pickSig(redSrc.sel, sigB, readySync)
                      ^ redSrc.flip;  // [RULE_10] [RULE_12]
    assign sigMode  = (mode == SLI_MODE_SIG) ||
                      (mode == SLI_MODE_COMM && !SERIAL_VARIANT);  // [RULE_06]

    always_comb begin
        next_green = 1'b0;
        next_red   = 1'b0;
        case (mode)
            SLI_MODE_DARK: begin
                next_green = 1'b0;  // [RULE_04]
                next_red   = 1'b0;
            end
            SLI_MODE_SIG, SLI_MODE_COMM: begin
                if (sigMode) begin
                    next_green = greenSig;  // [RULE_05] [RULE_07] [RULE_11]
                    next_red   = redSig;  // [RULE_09] [RULE_11]
                end else begin
                    next_green = ~commFault & activeSync;  // [RULE_01]
                    next_red   = commFault;  // [RULE_02]
                end
            end
            default: begin
                next_green = 1'b0;
                next_red   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lampGreen <= 1'b0;
            lampRed   <= 1'b0;
            readyLamp <= 1'b0;
        end else begin
            lampGreen <= next_green;
            lampRed   <= next_red;
            readyLamp <= readySync;  // [RULE_03]
        end
    end

    // ==========================================================
    // register read-back
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_MODE:   prdata <= {{30{mode[1]}}, mode};
                ADDR_GREEN:  prdata <= {23'h0, greenSrc};
                ADDR_RED:    prdata <= {23'h0, redSrc};
                ADDR_STATUS: prdata <= {27'h0, errorSync, activeSync,
                                        readyLamp, lampRed, lampGreen};
                ADDR_SIGLO:  prdata <= sigB[31:0];
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // checks
    property p_dark;
        @(posedge ref_clk) disable iff (reset)
        (mode == SLI_MODE_DARK) |=> (!lampGreen && !lampRed);
    endproperty
    a_dark: assert property (p_dark) else $error("lamp lit in dark mode"); // [RULE_04]

    property p_ready_lamp;
        @(posedge ref_clk) disable iff (reset)
        $rose(readyOut) |-> ##3 readyLamp;
    endproperty
    a_ready_lamp: assert property (p_ready_lamp) else $error("ready lamp late"); // [RULE_03]

    property p_err_red;
        @(posedge ref_clk) disable iff (reset)
        (mode == SLI_MODE_COMM && SERIAL_VARIANT && errorSync)
            |=> ##1 lampRed || mode != SLI_MODE_COMM;
    endproperty
    a_err_red: assert property (p_err_red) else $error("no red on error"); // [RULE_02]

    property p_comm_green;
        @(posedge ref_clk) disable iff (reset)
        (sigMode == 1'b0 && mode == SLI_MODE_COMM && !commFault
         && activeSync) |=> lampGreen;
    endproperty
    a_comm_green: assert property (p_comm_green) else $error("no green"); // [RULE_01]

    property p_no_both_comm;
        @(posedge ref_clk) disable iff (reset)
        (mode == SLI_MODE_COMM && !sigMode) |=> !(lampGreen && lampRed);
    endproperty
    a_no_both_comm: assert property (p_no_both_comm) else $error("both lit"); // [RULE_02]

    property p_green_sig;
        @(posedge ref_clk) disable iff (reset)
        sigMode |=> (lampGreen == $past(greenSig));
    endproperty
    a_green_sig: assert property (p_green_sig) else $error("green mismatch"); // [RULE_12]

    property p_red_sig;
        @(posedge ref_clk) disable iff (reset)
        sigMode |=> (lampRed == $past(redSig));
    endproperty
    a_red_sig: assert property (p_red_sig) else $error("red mismatch"); // [RULE_09]

    property p_const_off;
        @(posedge ref_clk) disable iff (reset)
        (sigMode && redSrc.sel == SIG_CONST_OFF) |=> lampRed == $past(redSrc.flip);
    endproperty
    a_const_off: assert property (p_const_off) else $error("const off wrong"); // [RULE_10]

    property p_ready_green;
        @(posedge ref_clk) disable iff (reset)
        (sigMode && greenSrc.sel == SIG_READY)
            |=> lampGreen == ($past(readySync) ^ $past(greenSrc.flip));
    endproperty
    a_ready_green: assert property (p_ready_green) else $error("ready green"); // [RULE_07]

    // ==========================================================
    // register bus checks; reads and stray writes leave settings alone
    sequence s_mode_wr;
        wrEn && paddr == ADDR_MODE && pwdata[1:0] != 2'b10;
    endsequence

    sequence s_no_change;
        $stable(mode) && $stable(greenSrc) && $stable(redSrc);
    endsequence

    property p_mode_wr;
        @(posedge ref_clk) disable iff (reset)
        s_mode_wr |=> mode == $past(pwdata[1:0]);
    endproperty
    a_mode_wr: assert property (p_mode_wr) // [RULE_05]
        else $error("mode not written");

    property p_mode_keep;
        @(posedge ref_clk) disable iff (reset)
        (wrEn && paddr == ADDR_MODE && pwdata[1:0] == 2'b10) |=> s_no_change;
    endproperty
    a_mode_keep: assert property (p_mode_keep)
        else $error("mode code two not ignored");

    property p_green_wr;
        @(posedge ref_clk) disable iff (reset)
        (wrEn && paddr == ADDR_GREEN) |=>
            greenSrc == {$past(pwdata[FLIP_BIT]),
                         $past(pwdata[SEL_LSB +: SEL_W])};
    endproperty
    a_green_wr: assert property (p_green_wr) // [RULE_07] [RULE_08]
        else $error("green setting not written");

    property p_red_wr;
        @(posedge ref_clk) disable iff (reset)
        (wrEn && paddr == ADDR_RED) |=>
            redSrc == {$past(pwdata[FLIP_BIT]),
                       $past(pwdata[SEL_LSB +: SEL_W])};
    endproperty
    a_red_wr: assert property (p_red_wr) // [RULE_09] [RULE_10]
        else $error("red setting not written");

    property p_bad_wr;
        @(posedge ref_clk) disable iff (reset)
        (wrEn && !mapped) |=> s_no_change;
    endproperty
    a_bad_wr: assert property (p_bad_wr)
        else $error("unmapped write changed a setting");

    property p_read_keep;
        @(posedge ref_clk) disable iff (reset)
        rdEn |=> s_no_change;
    endproperty
    a_read_keep: assert property (p_read_keep)
        else $error("read changed a setting");

    property p_bad_rd;
        @(posedge ref_clk) disable iff (reset)
        (psel && !penable && !pwrite && !mapped) |=> prdata == 32'h0000_0000;
    endproperty
    a_bad_rd: assert property (p_bad_rd)
        else $error("unmapped read not zero");

    // ==========================================================
    // lamp path checks
    sequence s_err_in;
        mode == SLI_MODE_COMM && !sigMode && errorSync;
    endsequence

    sequence s_red_on;
        commFault ##1 (lampRed || $past(mode) != SLI_MODE_COMM);
    endsequence

    property p_err_steps;
        @(posedge ref_clk) disable iff (reset)
        s_err_in |=> s_red_on;
    endproperty
    a_err_steps: assert property (p_err_steps) // [RULE_02]
        else $error("error did not reach red");

    property p_fault_clear;
        @(posedge ref_clk) disable iff (reset)
        (!errorSync && activeSync) |=> !commFault;
    endproperty
    a_fault_clear: assert property (p_fault_clear) // [RULE_02]
        else $error("fault not cleared");

    property p_fault_green_off;
        @(posedge ref_clk) disable iff (reset)
        (mode == SLI_MODE_COMM && !sigMode && commFault) |=> !lampGreen;
    endproperty
    a_fault_green_off: assert property (p_fault_green_off) // [RULE_02]
        else $error("green lit during fault");

    property p_ready_fall;
        @(posedge ref_clk) disable iff (reset)
        $fell(readyOut) |-> ##3 !readyLamp;
    endproperty
    a_ready_fall: assert property (p_ready_fall) // [RULE_03]
        else $error("ready lamp stays lit");

    property p_mode_sig;
        @(posedge ref_clk) disable iff (reset)
        (mode == SLI_MODE_SIG) |-> sigMode;
    endproperty
    a_mode_sig: assert property (p_mode_sig) // [RULE_05]
        else $error("signal mode not selected");
endmodule : sli_status_lamp

// >>> dv/sli_lamp_viewer.sv
// front-panel viewer model: turns the lamp elements into a colour code
module sli_lamp_viewer (
    input  wire logic       lampGreen,
    input  wire logic       lampRed,
    output logic      [1:0] colour
);
    timeunit 1ns;
    timeprecision 1ps;
    // the eye sees both elements at once; 3 reads as orange
    assign colour = {lampRed, lampGreen};
endmodule : sli_lamp_viewer

// >>> dv/tb_top.sv
// self-checking bench for the status lamp source selection block
module tb_top;
    import sli_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic         ref_clk, reset, psel, penable, pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         pready, pslverr, er, readyOut, commActive, commError;
    logic [127:0] outSignals;
    logic         lampGreen, lampRed, readyLamp;
    logic [1:0]   colour;
    logic [7:0]   gs, rs;
    logic         gf, rf;
    int           bad_count, checked, seed, r;
    logic [7:0]   codes [4] = '{8'h80, 8'h81, 8'h84, 8'h05};

    sli_status_lamp dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .outSignals(outSignals), .readyOut(readyOut),
        .commActive(commActive), .commError(commError),
        .lampGreen(lampGreen), .lampRed(lampRed), .readyLamp(readyLamp));
    sli_lamp_viewer viewer (.lampGreen(lampGreen), .lampRed(lampRed),
        .colour(colour));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // tasks and expectation functions
    task results;
        $display("mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            results();
        end
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // inputs pass two sync flops, the fault flop and the lamp flop
    task settle;
        repeat (5) @(posedge ref_clk);
    endtask : settle

    function logic sig(input logic [7:0] s);
        if (s < 8'h80) return outSignals[s[6:0]];
        if (s == SIG_CONST_ON) return 1'b1;
        if (s == SIG_READY) return readyOut;
        return 1'b0;
    endfunction : sig
    // ==========================================================
    // main sequence
    initial begin
        bad_count = 0; checked = 0; seed = 32'h805C;
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; outSignals = '0;
        readyOut = 1'b0; commActive = 1'b0; commError = 1'b0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_MODE, 32'h0);   chk(rd, 32'h1);
        apb(1'b0, ADDR_GREEN, 32'h0);  chk(rd, 32'h84);
        apb(1'b0, ADDR_RED, 32'h0);    chk(rd, 32'h80);
        apb(1'b0, 12'h020, 32'h0);     chk(rd, 32'h0);
        chk(er, 1'b1);
        chk(pready, 1'b1);
        commActive <= 1'b1;
        settle();  chk(colour, 2'b01);
        commError <= 1'b1;
        settle();  chk(colour, 2'b10);
        commError <= 1'b0;
        settle();  chk(colour, 2'b01);
        for (int i = 0; i < 6; i++) begin
            readyOut <= i[0];
            settle();  chk(readyLamp, i[0]);
        end
        apb(1'b1, ADDR_MODE, 32'h3);
        settle();  chk(colour, 2'b00);
        apb(1'b0, ADDR_MODE, 32'h0);   chk(rd, 32'hFFFFFFFF);
        apb(1'b1, ADDR_MODE, 32'h0);
        apb(1'b1, ADDR_MODE, 32'h2);
        apb(1'b0, ADDR_MODE, 32'h0);   chk(rd, 32'h0);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            gs = r[2] ? codes[r[1:0]] : {1'b0, r[9:3]};
            rs = r[12] ? codes[r[11:10]] : {1'b0, r[19:13]};
            gf = r[20]; rf = r[21];
            if (i % 4 == 0) begin
                rs = gs; gf = 1'b0; rf = 1'b1;
            end
            outSignals <= {$random(seed), $random(seed),
                           $random(seed), $random(seed)};
            readyOut <= r[22];
            commError <= r[23];
            apb(1'b1, ADDR_GREEN, {23'h0, gf, gs});
            apb(1'b1, ADDR_RED, {23'h0, rf, rs});
            settle();
            chk(lampGreen, sig(gs) ^ gf);
            chk(lampRed, sig(rs) ^ rf);
        end
        apb(1'b0, ADDR_SIGLO, 32'h0);  chk(rd, outSignals[31:0]);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, {27'h0, commError, commActive, readyOut,
                 sig(rs) ^ rf, sig(gs) ^ gf});
        results();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        results();
    end
endmodule : tb_top
